// >>> rtl/cbclk_pkg.sv
// Package of constants for the card-side clock and reset control block
package cbclk_pkg;

    // ****************************************
    // Clock divider settings
    // ****************************************
    localparam int unsigned DIV_W         = 8;
    localparam logic [7:0]  DIV_FULL      = 8'h01;
    localparam logic [7:0]  DIV_SLOW_DEF  = 8'h08;

    // ****************************************
    // Clock-run handshake timing
    // ****************************************
    localparam int unsigned CLKRUN_WAIT_NS   = 100;
    localparam int unsigned CORE_PERIOD_NS   = 5;
    localparam int unsigned CLKRUN_WAIT_CYC  =
        (CLKRUN_WAIT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [7:0]  CLKRUN_WAIT_LAST = 8'(CLKRUN_WAIT_CYC - 1);
    localparam logic [7:0]  CLKRUN_SETTLE    = 8'h02;

    // ****************************************
    // Clock mode states, one-hot
    // ****************************************
    typedef enum logic [3:0] {
        CBCLK_RUN      = 4'h1,
        CBCLK_ANNOUNCE = 4'h2,
        CBCLK_SLOW     = 4'h4,
        CBCLK_STOP     = 4'h8
    } cbclk_state_t;

endpackage

// >>> rtl/cbclk_div_if.sv
// Interface between the clock mode logic and the clock divider
`timescale 1ns/1ps
interface cbclk_div_if;
    logic [7:0] half_period;
    logic       hold_low;
    logic       clk_level;
    logic       rise;

    modport ctrl (output half_period, output hold_low, input clk_level, input rise);
    modport div  (input half_period, input hold_low, output clk_level, output rise);
endinterface

// >>> rtl/cbclk_divider.sv
// Card-side clock divider with stop-low control
`timescale 1ns/1ps
module cbclk_divider (
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    // Control side
    cbclk_div_if.div   dv
);

    logic [7:0] count;
    logic       level;

    assign dv.clk_level = level;

    // ****************************************
    // Divider
    // ****************************************
    // RULE3: stop held low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
            level <= 1'b0;
            dv.rise <= 1'b0;
        end else if (dv.hold_low && !level) begin
            count <= 8'h00;
            dv.rise <= 1'b0;
        end else if (count + 8'h01 >= dv.half_period) begin
            count <= 8'h00;
            level <= ~level;
            dv.rise <= ~level;
        end else begin
            count <= count + 8'h01;
            dv.rise <= 1'b0;
        end
    end

endmodule

// >>> rtl/cbclk_ctrl.sv
// Card-side clock generation, clock-run handshake and card reset control
//
// Functional notes
// RULE1: Card signals sample on card clock rise, except reset, clock-run and sideband lines.
// RULE2: Normal operation runs card clock at host bus clock rate.
// RULE3: For power saving, card clock may stop low or slow down.
// RULE4: Card requests faster clock by asserting the clock-run line.
// RULE5: Controller announces a slowdown on clock-run before slowing.
// RULE6: Card returns its registers and sequencers to known state under reset.
// RULE7: Card floats its interface outputs under reset.
// RULE8: Controller drives floated card signals to valid levels under reset.
// RULE9: Card reset may be asserted at any moment, unaligned.
// RULE10: Card reset release is aligned to card clock rising edge.
// RULE11: Clock-run is open-drain; controller releases it, card pulls it back.
`timescale 1ns/1ps
module cbclk_ctrl (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Host bus clock, sampled
    input  wire logic        host_bus_clk,
    // Power control
    input  wire logic        slow_req,
    input  wire logic        stop_req,
    input  wire logic [7:0]  slow_half_period,
    input  wire logic        card_reset_req,
    // Card pins
    output logic             card_side_clock,
    output logic             card_side_reset_n,
    input  wire logic        card_clock_run_request_in,
    output logic             card_clock_run_request_out,
    output logic             card_clock_run_request_oe,
    output logic             card_park_oe,
    // Status
    output logic             clock_slowed,
    output logic             clock_stopped,
    output logic [7:0]       host_half_period
);

    cbclk_div_if dv ();

    cbclk_divider u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .dv       (dv.div)
    );

    cbclk_pkg::cbclk_state_t state;
    cbclk_pkg::cbclk_state_t next_state;

    logic [1:0] hclk_sync;
    logic       hclk_prev;
    logic [7:0] hcnt;
    logic [1:0] run_sync;
    logic [7:0] wait_cnt;
    logic       rst_pend;
    logic       power_req;
    logic       card_wants_fast;
    logic       run_hold;

    function automatic logic [7:0] cbclk_sat_inc(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hclk_sync <= 2'h0;
            run_sync  <= 2'h3;
        end else begin
            hclk_sync <= {hclk_sync[0], host_bus_clk};
            run_sync  <= {run_sync[0], card_clock_run_request_in};
        end
    end

    // ****************************************
    // Host bus clock half-period measurement
    // ****************************************
    // RULE2: match host rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hclk_prev        <= 1'b0;
            hcnt             <= 8'h00;
            host_half_period <= cbclk_pkg::DIV_FULL;
        end else begin
            hclk_prev <= hclk_sync[1];
            if (hclk_sync[1] != hclk_prev) begin
                hcnt             <= 8'h01;
                host_half_period <= (hcnt == 8'h00) ? cbclk_pkg::DIV_FULL : hcnt;
            end else begin
                hcnt <= cbclk_sat_inc(hcnt);
            end
        end
    end

    // ****************************************
    // Power and card speed requests
    // ****************************************
    assign power_req = slow_req || stop_req;

    // RULE4: card pulls clock-run
    always_comb begin
        card_wants_fast = 1'b0;
        if (state == cbclk_pkg::CBCLK_ANNOUNCE) begin
            card_wants_fast = !run_sync[1] && (wait_cnt >= cbclk_pkg::CLKRUN_SETTLE);
        end else if (state != cbclk_pkg::CBCLK_RUN) begin
            card_wants_fast = !run_sync[1];
        end
    end

    // ****************************************
    // Hold full speed after a card request
    // ****************************************
    // RULE11: card keeps speed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_hold <= 1'b0;
        end else if (!power_req) begin
            run_hold <= 1'b0;
        end else if (card_wants_fast) begin
            run_hold <= 1'b1;
        end
    end

    // ****************************************
    // Clock mode state machine
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            cbclk_pkg::CBCLK_RUN: begin
                // RULE5: announce before slowing
                if (power_req && !run_hold) begin
                    next_state = cbclk_pkg::CBCLK_ANNOUNCE;
                end
            end
            cbclk_pkg::CBCLK_ANNOUNCE: begin
                // RULE11: card pulls line back
                if (card_wants_fast || !power_req) begin
                    next_state = cbclk_pkg::CBCLK_RUN;
                end else if (wait_cnt == cbclk_pkg::CLKRUN_WAIT_LAST) begin
                    next_state = stop_req ? cbclk_pkg::CBCLK_STOP : cbclk_pkg::CBCLK_SLOW;
                end
            end
            cbclk_pkg::CBCLK_SLOW, cbclk_pkg::CBCLK_STOP: begin
                // RULE4: card asks for speed
                if (card_wants_fast || !power_req) begin
                    next_state = cbclk_pkg::CBCLK_RUN;
                end else if (stop_req) begin
                    next_state = cbclk_pkg::CBCLK_STOP;
                end else begin
                    next_state = cbclk_pkg::CBCLK_SLOW;
                end
            end
            default: next_state = cbclk_pkg::CBCLK_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= cbclk_pkg::CBCLK_RUN;
            wait_cnt <= 8'h00;
        end else begin
            state    <= next_state;
            wait_cnt <= (state == cbclk_pkg::CBCLK_ANNOUNCE) ? cbclk_sat_inc(wait_cnt) : 8'h00;
        end
    end

    // ****************************************
    // Divider control
    // ****************************************
    // RULE3: slow or stop
    always_comb begin
        dv.hold_low = (state == cbclk_pkg::CBCLK_STOP);
        if (state != cbclk_pkg::CBCLK_SLOW) begin
            dv.half_period = host_half_period;
        end else if (slow_half_period == 8'h00) begin
            dv.half_period = cbclk_pkg::DIV_SLOW_DEF;
        end else begin
            dv.half_period = slow_half_period;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // RULE1: card clock launch
    // RULE11: open-drain clock-run
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_side_clock            <= 1'b0;
            card_clock_run_request_out <= 1'b0;
            card_clock_run_request_oe  <= 1'b1;
            clock_slowed               <= 1'b0;
            clock_stopped              <= 1'b0;
        end else begin
            card_side_clock            <= dv.clk_level;
            card_clock_run_request_out <= 1'b0;
            card_clock_run_request_oe  <= (next_state == cbclk_pkg::CBCLK_RUN);
            clock_slowed               <= (state == cbclk_pkg::CBCLK_SLOW);
            clock_stopped              <= (state == cbclk_pkg::CBCLK_STOP) && !dv.clk_level;
        end
    end

    // ****************************************
    // Card reset
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pend          <= 1'b1;
            card_side_reset_n <= 1'b0;
            card_park_oe      <= 1'b1;
        end else if (card_reset_req) begin
            // RULE9: unaligned assertion
            rst_pend          <= 1'b1;
            card_side_reset_n <= 1'b0;
            // RULE8: park floated signals
            card_park_oe      <= 1'b1;
        end else if (rst_pend && dv.rise) begin
            // RULE10: release on clock rise
            rst_pend          <= 1'b0;
            card_side_reset_n <= 1'b1;
            card_park_oe      <= 1'b0;
        end
    end

endmodule

// >>> verification/cbclk_ctrl_assertions.sv
// Port assertions for the card-side clock and reset control block
`timescale 1ns/1ps
module cbclk_ctrl_assertions (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // Watched ports
    input wire logic       stop_req,
    input wire logic       card_reset_req,
    input wire logic       card_side_clock,
    input wire logic       card_side_reset_n,
    input wire logic       card_clock_run_request_in,
    input wire logic       card_clock_run_request_out,
    input wire logic       card_clock_run_request_oe,
    input wire logic       card_park_oe,
    input wire logic       clock_slowed,
    input wire logic       clock_stopped
);
    // ****************************************
    // Checks
    // ****************************************
    logic [7:0] low_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Cycles since clock-run was last pulled by the controller
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 8'h00;
        else if (card_clock_run_request_oe) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    req_asserts_a: assert property (card_reset_req |=> !card_side_reset_n)
        else $error("card reset not asserted after request");
    rst_cause_a: assert property ($fell(card_side_reset_n) |-> $past(card_reset_req))
        else $error("card reset asserted without request");
    release_sync_a: assert property ($rose(card_side_reset_n) |-> card_side_clock || $past(card_side_clock))
        else $error("card reset released off the card clock rise");
    park_in_rst_a: assert property (!card_side_reset_n && $past(!card_side_reset_n) |-> card_park_oe)
        else $error("floated card signals not parked");
    announce_wait_a: assert property ($rose(clock_slowed || clock_stopped)
        |-> low_cnt > 8'(cbclk_pkg::CLKRUN_WAIT_CYC))
        else $error("slowdown without announce");
    stop_low_a: assert property (clock_stopped && $past(clock_stopped) && stop_req && $past(stop_req)
        |-> !card_side_clock)
        else $error("stopped clock not low");
    out_zero_a: assert property (card_clock_run_request_out == 1'b0)
        else $error("clock-run driven high");
    card_pull_a: assert property (!card_clock_run_request_in && !card_clock_run_request_oe
        |-> ##[1:5] card_clock_run_request_oe)
        else $error("card speed request ignored");
endmodule
bind cbclk_ctrl cbclk_ctrl_assertions chk_i (.core_clk, .rst_n, .stop_req, .card_reset_req, .card_side_clock,
    .card_side_reset_n, .card_clock_run_request_in, .card_clock_run_request_out, .card_clock_run_request_oe,
    .card_park_oe, .clock_slowed, .clock_stopped);

// >>> verification/cbclk_card_model.sv
// Model of an inserted card on the clock-run and reset pins
`timescale 1ns/1ps
module cbclk_card_model (
    // Card pins
    input  wire logic        card_side_clock,
    input  wire logic        card_side_reset_n,
    input  wire logic        ctrl_pull,
    output logic             clock_run_pin,
    // Bench control
    input  wire logic        want_fast,
    output logic [15:0]      rise_cnt
);
    // pull-up line, card pulls for speed, floats in reset
    assign clock_run_pin = !(ctrl_pull || (want_fast && card_side_reset_n));
    // card state counts clock rises, cleared by reset
    always_ff @(posedge card_side_clock or negedge card_side_reset_n) begin
        if (!card_side_reset_n) rise_cnt <= 16'h0000;
        else rise_cnt <= rise_cnt + 16'h0001;
    end
endmodule

// >>> verification/cbclk_ctrl_test.sv
// Testbench for the card-side clock and reset control block
`timescale 1ns/1ps
module cbclk_ctrl_test;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        core_clk = 1'b0, rst_n = 1'b0, host_bus_clk = 1'b0, want_fast = 1'b0;
    logic        slow_req = 1'b0, stop_req = 1'b0, card_reset_req = 1'b1;
    logic [7:0]  slow_half_period = 8'h04, host_half_period;
    logic        card_side_clock, card_side_reset_n, card_clock_run_request_in, card_clock_run_request_out;
    logic        card_clock_run_request_oe, card_park_oe, clock_slowed, clock_stopped;
    logic [15:0] rise_cnt, r;
    int          error_cnt = 0, checks_done = 0, p, n;
    always #2.5 core_clk = ~core_clk;
    initial begin
        #1.3;
        forever #80 host_bus_clk = ~host_bus_clk;
    end
    cbclk_ctrl dut (.core_clk, .rst_n, .host_bus_clk, .slow_req, .stop_req, .slow_half_period, .card_reset_req,
        .card_side_clock, .card_side_reset_n, .card_clock_run_request_in, .card_clock_run_request_out,
        .card_clock_run_request_oe, .card_park_oe, .clock_slowed, .clock_stopped, .host_half_period);
    cbclk_card_model card (.card_side_clock, .card_side_reset_n, .ctrl_pull(card_clock_run_request_oe),
        .clock_run_pin(card_clock_run_request_in), .want_fast, .rise_cnt);
    // ****************************************
    // Helpers and scenarios
    // ****************************************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task cyc; @(posedge core_clk); #1; endtask
    task tmo;
        if (n >= 400) begin
            error_cnt++;
            $display("Error at %0t: wait timed out", $time);
            finish_test;
        end
    endtask
    task per;
        for (int i = 0; i < 2; i++) begin
            for (p = 0; p < 300 && card_side_clock; p++) cyc;
            for (; p < 300 && !card_side_clock; p++) cyc;
        end
    endtask
    task rel_card;
        @(posedge core_clk) card_reset_req <= 1'b0;
        for (n = 0; n < 400 && !card_side_reset_n; n++) cyc;
        tmo;
        chk(card_side_clock, 1);
        chk(card_park_oe, 0);
    endtask
    task t_full;
        repeat (200) cyc;
        chk(host_half_period, 16'h0010);
        per;
        chk(16'(p), 16'h0020);
    endtask
    task t_slow;
        @(posedge core_clk) slow_req <= 1'b1;
        cyc;
        cyc;
        chk(card_clock_run_request_oe, 0);
        for (n = 0; n < 400 && !clock_slowed; n++) cyc;
        tmo;
        chk(n >= cbclk_pkg::CLKRUN_WAIT_CYC, 1);
        per;
        chk(16'(p), 16'(2 * slow_half_period));
        @(posedge core_clk) slow_req <= 1'b0;
        repeat (4) cyc;
        chk(card_clock_run_request_oe, 1);
        per;
        chk(16'(p), 16'h0020);
    endtask
    task t_wake;
        @(posedge core_clk) slow_req <= 1'b1;
        for (n = 0; n < 400 && !clock_slowed; n++) cyc;
        tmo;
        @(posedge core_clk) want_fast <= 1'b1;
        repeat (5) cyc;
        chk(clock_slowed, 0);
        chk(card_clock_run_request_oe, 1);
        @(posedge core_clk) slow_req <= 1'b0;
        @(posedge core_clk) want_fast <= 1'b0;
    endtask
    task t_abort;
        @(posedge core_clk) slow_req <= 1'b1;
        repeat (5) cyc;
        @(posedge core_clk) want_fast <= 1'b1;
        repeat (6) cyc;
        chk(card_clock_run_request_oe, 1);
        chk(clock_slowed, 0);
        @(posedge core_clk) slow_req <= 1'b0;
        @(posedge core_clk) want_fast <= 1'b0;
    endtask
    task t_stop;
        @(posedge core_clk) stop_req <= 1'b1;
        for (n = 0; n < 400 && !clock_stopped; n++) cyc;
        tmo;
        r = rise_cnt;
        repeat (64) cyc;
        chk(card_side_clock, 0);
        chk(rise_cnt, r);
        @(posedge core_clk) stop_req <= 1'b0;
        for (n = 0; n < 400 && clock_stopped; n++) cyc;
        tmo;
    endtask
    task t_card_reset;
        @(posedge core_clk) card_reset_req <= 1'b1;
        cyc;
        cyc;
        chk(card_side_reset_n, 0);
        chk(card_park_oe, 1);
        rel_card;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        cyc;
        chk(card_side_reset_n, 0);
        chk(card_park_oe, 1);
        rel_card;
        t_full;
        t_slow;
        t_abort;
        t_wake;
        t_stop;
        t_card_reset;
        finish_test;
    end
endmodule
